//--- sdrtc_ctrl.sv
// sdram controller: power-up init and command spacing
`timescale 1ns/1ps
module sdrtc_ctrl #(
    parameter int unsigned PWRUP_CYCLES = sdrtc_pkg::C_PWRUP,
    parameter int unsigned RAS_MAX_CYCLES = sdrtc_pkg::C_RAS_MAX,
    parameter int unsigned ROW_W = 13,
    parameter int unsigned COL_W = 9,
    parameter int unsigned DATA_W = 32
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // user request
    input wire logic i_req_valid,
    input wire sdrtc_pkg::sdrtc_op_e i_req_op,
    input wire logic [1:0] i_req_bank,
    input wire logic [ROW_W-1:0] i_req_row,
    input wire logic [COL_W-1:0] i_req_col,
    input wire logic [DATA_W-1:0] i_req_wdata,
    input wire logic i_rl3,
    output logic o_req_ready,
    output logic o_init_done,
    output logic o_rd_valid,
    output logic [DATA_W-1:0] o_rd_data,
    // memory pins
    output logic o_cke,
    output logic o_cs_n,
    output logic o_ras_n,
    output logic o_cas_n,
    output logic o_we_n,
    output logic [1:0] o_ba,
    output logic [12:0] o_addr,
    output logic [3:0] o_dqm,
    output logic [DATA_W-1:0] o_dq_out,
    output logic o_dq_oe,
    input wire logic [DATA_W-1:0] i_dq_in
);
    typedef enum logic [3:0] {
        S_PWRUP, S_PREALL, S_MRS, S_IREF, S_IDLE, S_ACT, S_COL, S_WREC,
        S_PRE, S_REF, S_SREF, S_SRX, S_WAIT
    } sdrtc_state_e;

    sdrtc_state_e state_q, state_d, next_q, next_d;
    logic [17:0] wait_q, wait_d;
    logic [17:0] ras_q;
    logic [1:0] refs_q;
    logic [3:0] cmd_q, cmd_d;
    logic [12:0] addr_d;
    logic [4:0] rdpipe_q;
    logic [DATA_W-1:0] dq_s1_q, dq_s2_q;
    logic [17:0] ras_max_c;
    logic [2:0] rl_code;
    logic waited, in_init;

    assign ras_max_c = 18'(RAS_MAX_CYCLES);
    assign waited = (wait_q == 18'h0);
    // the waits between init steps still count as init
    assign in_init = (state_q == S_PWRUP) || (state_q == S_PREALL) || (state_q == S_MRS)
        || (state_q == S_IREF)
        || (state_q == S_WAIT && (next_q == S_MRS || next_q == S_IREF));
    assign rl_code = i_rl3 ? sdrtc_pkg::RL_3 : sdrtc_pkg::RL_2;
    assign o_req_ready = (state_q == S_IDLE);
    assign o_init_done = !in_init;

    always_comb begin
        state_d = state_q;
        next_d = next_q;
        wait_d = waited ? wait_q : wait_q - 18'h1;
        cmd_d = sdrtc_pkg::CMD_NOP;
        addr_d = o_addr;
        case (state_q)
            S_PWRUP: if (waited) begin
                state_d = S_PREALL;
            end
            S_PREALL: begin
                cmd_d = sdrtc_pkg::CMD_PRE;
                addr_d = 13'h1 << sdrtc_pkg::AP_BIT;
                wait_d = 18'(sdrtc_pkg::C_RP - 1);
                state_d = S_WAIT;
                next_d = S_MRS;
            end
            S_MRS: if (waited) begin
                cmd_d = sdrtc_pkg::CMD_MRS;
                addr_d = 13'({rl_code, 1'b0, sdrtc_pkg::BURST_1});
                wait_d = 18'(sdrtc_pkg::T_MRS_CLK - 1);
                state_d = S_WAIT;
                next_d = S_IREF;
            end
            S_IREF: begin
                cmd_d = sdrtc_pkg::CMD_REF;
                wait_d = 18'(sdrtc_pkg::C_RC - 1);
                state_d = S_WAIT;
                next_d = (refs_q == 2'(sdrtc_pkg::INIT_REFRESHES - 1)) ? S_IDLE : S_IREF;
            end
            S_IDLE: if (i_req_valid) begin
                case (i_req_op)
                    sdrtc_pkg::OP_REFRESH: state_d = S_REF;
                    sdrtc_pkg::OP_SELFREF: state_d = S_SREF;
                    default: state_d = S_ACT;
                endcase
            end
            S_ACT: begin
                cmd_d = sdrtc_pkg::CMD_ACT;
                addr_d = 13'(i_req_row);
                wait_d = 18'(sdrtc_pkg::C_RCD - 1);
                state_d = S_WAIT;
                next_d = S_COL;
            end
            S_COL: begin
                cmd_d = (i_req_op == sdrtc_pkg::OP_WRITE) ? sdrtc_pkg::CMD_WR
                    : sdrtc_pkg::CMD_RD;
                addr_d = 13'(i_req_col);
                wait_d = 18'(sdrtc_pkg::T_WR_CLK);
                state_d = S_WREC;
            end
            S_WREC: if (waited && ras_q >= 18'(sdrtc_pkg::C_RAS)) begin
                state_d = S_PRE;
            end
            S_PRE: begin
                cmd_d = sdrtc_pkg::CMD_PRE;
                addr_d = 13'h0;
                wait_d = 18'(sdrtc_pkg::C_RC > sdrtc_pkg::C_RP + sdrtc_pkg::C_RAS ?
                    sdrtc_pkg::C_RC - sdrtc_pkg::C_RAS : sdrtc_pkg::C_RP) - 18'h1;
                state_d = S_WAIT;
                next_d = S_IDLE;
            end
            S_REF: begin
                cmd_d = sdrtc_pkg::CMD_REF;
                wait_d = 18'(sdrtc_pkg::C_RC - 1);
                state_d = S_WAIT;
                next_d = S_IDLE;
            end
            S_SREF: begin
                wait_d = 18'(sdrtc_pkg::C_RAS);
                if (!i_req_valid) begin
                    state_d = S_SRX;
                end
            end
            S_SRX: begin
                wait_d = 18'(sdrtc_pkg::C_SRX > sdrtc_pkg::C_RC ? sdrtc_pkg::C_SRX
                    : sdrtc_pkg::C_RC);
                state_d = S_WAIT;
                next_d = S_IDLE;
            end
            S_WAIT: if (waited) begin
                state_d = next_q;
            end
            default: state_d = S_PWRUP;
        endcase
        // refresh only on the entry cycle; the exit cycle shows a no-operation
        if (state_q == S_SREF && state_d == S_SREF) begin
            cmd_d = o_cke ? sdrtc_pkg::CMD_REF : sdrtc_pkg::CMD_NOP;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state_q <= S_PWRUP;
            next_q <= S_IDLE;
            wait_q <= 18'(PWRUP_CYCLES - 1);
            cmd_q <= sdrtc_pkg::CMD_NOP;
            o_addr <= 13'h0;
            refs_q <= 2'h0;
            o_cke <= 1'b1;
        end else begin
            state_q <= state_d;
            next_q <= next_d;
            wait_q <= wait_d;
            cmd_q <= cmd_d;
            o_addr <= addr_d;
            o_cke <= !(state_q == S_SREF && state_d == S_SREF);
            if (state_q == S_IREF) begin
                refs_q <= refs_q + 2'h1;
            end
        end
    end

    // row open timer and read return
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ras_q <= 18'h0;
            o_ba <= 2'h0;
            o_dqm <= 4'hf;
            o_dq_out <= '0;
            o_dq_oe <= 1'b0;
            rdpipe_q <= 5'h0;
            dq_s1_q <= '0;
            dq_s2_q <= '0;
            o_rd_data <= '0;
            o_rd_valid <= 1'b0;
        end else begin
            ras_q <= (cmd_d == sdrtc_pkg::CMD_ACT) ? 18'h0 : ras_q + 18'(ras_q < ras_max_c);
            if (state_q == S_ACT) begin
                o_ba <= i_req_bank;
            end
            o_dqm <= in_init ? 4'hf : 4'h0;
            o_dq_oe <= (cmd_d == sdrtc_pkg::CMD_WR);
            o_dq_out <= i_req_wdata;
            rdpipe_q <= {rdpipe_q[3:0], cmd_q == sdrtc_pkg::CMD_RD};
            dq_s1_q <= i_dq_in;
            dq_s2_q <= dq_s1_q;
            // latency plus two synchroniser stages, in step with o_rd_data
            o_rd_valid <= i_rl3 ? rdpipe_q[4] : rdpipe_q[3];
            o_rd_data <= dq_s2_q;
        end
    end

    assign {o_cs_n, o_ras_n, o_cas_n, o_we_n} = cmd_q;

    a_init_dqm_high: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !o_init_done |-> o_dqm == 4'hf) else $error("byte masks low during init");
    a_act_to_col: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (cmd_q == sdrtc_pkg::CMD_ACT) |=> (cmd_q != sdrtc_pkg::CMD_RD
        && cmd_q != sdrtc_pkg::CMD_WR)) else $error("column too soon after activate");
    a_mrs_gap: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (cmd_q == sdrtc_pkg::CMD_MRS) |=> cmd_q == sdrtc_pkg::CMD_NOP)
        else $error("command right after mode set");
    a_pre_to_act: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (cmd_q == sdrtc_pkg::CMD_PRE) |=> cmd_q == sdrtc_pkg::CMD_NOP)
        else $error("command too soon after precharge");
    a_ras_min: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (cmd_q == sdrtc_pkg::CMD_PRE && o_init_done) |-> ras_q >= 18'(sdrtc_pkg::C_RAS))
        else $error("row closed too early");
    a_cke_init: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !o_init_done |-> o_cke) else $error("clock gate low in init");
    a_ref_spacing: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (cmd_q == sdrtc_pkg::CMD_REF && o_cke) |=> cmd_q == sdrtc_pkg::CMD_NOP)
        else $error("command after refresh");
    a_ready_idle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_req_ready |-> cmd_q != sdrtc_pkg::CMD_ACT) else $error("ready while active");
    c_init: cover property (@(posedge i_clk_sys) $rose(o_init_done));
    c_read: cover property (@(posedge i_clk_sys) o_rd_valid);
    c_write: cover property (@(posedge i_clk_sys) o_dq_oe);
    c_selfref: cover property (@(posedge i_clk_sys) $fell(o_cke));
endmodule

//--- sdrtc_pkg.sv
// constants for the sdram timing and init controller
package sdrtc_pkg;
    localparam int unsigned CLK_MHZ = 20;
    localparam int unsigned T_RRD_NS = 15;
    localparam int unsigned T_RP_NS = 20;
    localparam int unsigned T_RAS_NS = 44;
    localparam int unsigned T_RAS_MAX_NS = 120000;
    localparam int unsigned T_SRX_NS = 70;
    localparam int unsigned T_RCD_NS = 20;
    localparam int unsigned T_RC_NS = 66;
    localparam int unsigned T_PWRUP_US = 200;
    localparam int unsigned T_WR_CLK = 2;
    localparam int unsigned T_MRS_CLK = 2;
    localparam int unsigned COL_GAP_CLK = 1;
    localparam int unsigned INIT_REFRESHES = 2;
    // least times round up, longest times round down
    localparam int unsigned C_RRD = (T_RRD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned C_RP = (T_RP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned C_RAS = (T_RAS_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned C_RAS_MAX = (T_RAS_MAX_NS * CLK_MHZ) / 1000;
    localparam int unsigned C_SRX = (T_SRX_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned C_RCD = (T_RCD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned C_RC = (T_RC_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned C_PWRUP = T_PWRUP_US * CLK_MHZ;
    // command encodings {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam int unsigned AP_BIT = 10;
    localparam logic [2:0] RL_2 = 3'h2;
    localparam logic [2:0] RL_3 = 3'h3;
    localparam int unsigned RL_LSB = 4;
    localparam logic [2:0] BURST_1 = 3'h0;
    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_REFRESH,
        OP_SELFREF
    } sdrtc_op_e;
endpackage

//--- sdrtc_mem_model.sv
// behavioural memory device that stores words and flags badly spaced commands
`timescale 1ns/1ps
module sdrtc_mem_model #(
    parameter int PWRUP = 20
) (
    // memory pins driven by the controller
    input wire logic i_clk_sys,
    input wire logic i_por,
    input wire logic i_cke,
    input wire logic [3:0] i_cmd,
    input wire logic [1:0] i_ba,
    input wire logic [12:0] i_addr,
    input wire logic [3:0] i_dqm,
    input wire logic [31:0] i_dq,
    // read data and status
    output logic [31:0] o_dq,
    output logic [2:0] o_rl,
    output int o_viol
);
    int cyc, t_any, t_wr, t_mrs, t_srx, t_rd, t_ref, refs, step, rd_key;
    int t_act[4];
    int t_pre[4];
    logic [12:0] row[4];
    logic [31:0] mem[int];
    logic cke_q;
    wire [23:0] key = {i_ba, row[i_ba], i_addr[8:0]};
    always @(posedge i_clk_sys or posedge i_por) begin
        if (i_por) begin
            {cyc, step, refs, o_viol} = '0;
            {t_any, t_wr, t_mrs, t_srx, t_rd, t_ref} = {6{-32'sd99}};
            t_act = '{default: -99};
            t_pre = '{default: -99};
            o_rl = 3'h0;
            o_dq = 32'h0;
            cke_q = 1'b1;
        end else begin
            cyc++;
            // released bus shows the inverse of the last value
            o_dq <= (cyc == t_rd + o_rl - 1) ? mem[rd_key] : ~o_dq;
            if (step == 0 && i_dqm !== 4'hf) o_viol++;
            if (i_cke && !cke_q) begin
                t_srx = cyc;
                // only a no-operation or a deselect may mark the exit
                if (!i_cmd[3] && i_cmd != sdrtc_pkg::CMD_NOP) o_viol++;
            end
            if (cke_q && !i_cmd[3] && i_cmd != sdrtc_pkg::CMD_NOP) begin
                if (cyc - t_mrs < 2) o_viol++;
                if (step == 0 && (cyc < PWRUP || i_cmd != sdrtc_pkg::CMD_PRE
                    || !i_addr[10])) o_viol++;
                if (step == 1 && i_cmd != sdrtc_pkg::CMD_MRS) o_viol++;
                case (i_cmd)
                    sdrtc_pkg::CMD_PRE: begin
                        for (int b = 0; b < 4; b++) begin
                            if (i_addr[10] || b == i_ba) begin
                                if (t_act[b] > t_pre[b] && cyc - t_act[b] < sdrtc_pkg::C_RAS)
                                    o_viol++;
                                if (cyc - t_wr < 2) o_viol++;
                                t_pre[b] = cyc;
                            end
                        end
                        if (step == 0) step = 1;
                    end
                    sdrtc_pkg::CMD_MRS: begin
                        o_rl = i_addr[6:4];
                        if (o_rl != 3'h2 && o_rl != 3'h3) o_viol++;
                        t_mrs = cyc;
                        if (step == 1) step = 2;
                    end
                    sdrtc_pkg::CMD_REF: begin
                        if (i_cke) begin
                            for (int b = 0; b < 4; b++)
                                if (cyc - t_pre[b] < sdrtc_pkg::C_RP) o_viol++;
                            if (cyc - t_ref < sdrtc_pkg::C_RC) o_viol++;
                            t_ref = cyc;
                            refs++;
                            if (step == 2 && refs >= 2) step = 3;
                        end
                    end
                    sdrtc_pkg::CMD_ACT: begin
                        if (step < 3) o_viol++;
                        if (cyc - t_pre[i_ba] < sdrtc_pkg::C_RP) o_viol++;
                        if (cyc - t_act[i_ba] < sdrtc_pkg::C_RC) o_viol++;
                        if (cyc - t_any < sdrtc_pkg::C_RRD) o_viol++;
                        if (cyc - t_srx < sdrtc_pkg::C_SRX) o_viol++;
                        row[i_ba] = i_addr;
                        t_act[i_ba] = cyc;
                        t_any = cyc;
                    end
                    default: begin
                        // column commands may come on consecutive clocks
                        if (cyc - t_act[i_ba] < sdrtc_pkg::C_RCD) o_viol++;
                        if (i_cmd == sdrtc_pkg::CMD_RD) begin
                            t_rd = cyc;
                            rd_key = int'(key);
                        end else if (i_cmd == sdrtc_pkg::CMD_WR) begin
                            mem[int'(key)] = i_dq;
                            t_wr = cyc;
                        end
                    end
                endcase
            end
            cke_q = i_cke;
        end
    end
endmodule

//--- sdram_timing_and_init_test.sv
// self-checking bench of the controller against the memory model
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (got), (exp)); end end
module sdram_timing_and_init_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic valid = 1'b0;
    logic rl3 = 1'b0;
    sdrtc_pkg::sdrtc_op_e op = sdrtc_pkg::OP_READ;
    logic [1:0] bank = 2'h0;
    logic [12:0] row = 13'h0;
    logic [8:0] col = 9'h0;
    logic [31:0] wd = 32'h0;
    wire ready, done, rvalid, cke, cs_n, ras_n, cas_n, we_n, dq_oe;
    wire [31:0] rdata, dq_out, mdq;
    wire [1:0] ba;
    wire [12:0] addr;
    wire [3:0] dqm;
    wire [2:0] rl;
    wire [31:0] dq_in = dq_oe ? dq_out : mdq;
    int viol;
    int errors = 0;
    int samples_checked = 0;
    always #25 clk = ~clk;
    sdrtc_ctrl #(.PWRUP_CYCLES(20)) sdrtc_ctrl_inst (.i_clk_sys(clk), .i_rst(rst),
        .i_req_valid(valid), .i_req_op(op), .i_req_bank(bank), .i_req_row(row),
        .i_req_col(col), .i_req_wdata(wd), .i_rl3(rl3), .o_req_ready(ready),
        .o_init_done(done), .o_rd_valid(rvalid), .o_rd_data(rdata), .o_cke(cke),
        .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba),
        .o_addr(addr), .o_dqm(dqm), .o_dq_out(dq_out), .o_dq_oe(dq_oe), .i_dq_in(dq_in));
    sdrtc_mem_model #(.PWRUP(20)) sdrtc_mem_model_inst (.i_clk_sys(clk), .i_por(rst),
        .i_cke(cke), .i_cmd({cs_n, ras_n, cas_n, we_n}), .i_ba(ba), .i_addr(addr),
        .i_dqm(dqm), .i_dq(dq_out), .o_dq(mdq), .o_rl(rl), .o_viol(viol));
    task automatic print_verdict();
        if (errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic step_neg(input int n);
        if (n > 500) begin
            errors++;
            print_verdict();
        end
        @(negedge clk);
    endtask
    task automatic power_up(input logic lat3);
        @(posedge clk);
        rst <= 1'b1;
        rl3 <= lat3;
        valid <= 1'b0;
        repeat (1) @(posedge clk);
        @(negedge clk);
        `CHK({cke, cs_n, ras_n, cas_n, we_n, dqm, dq_oe}, 10'h2fe)
        @(posedge clk);
        rst <= 1'b0;
        for (int n = 0; done !== 1'b1; n++) step_neg(n);
        `CHK(viol, 0)
        `CHK(rl, lat3 ? sdrtc_pkg::RL_3 : sdrtc_pkg::RL_2)
    endtask
    task automatic request(input sdrtc_pkg::sdrtc_op_e o, input logic [1:0] b,
                           input logic [31:0] d);
        @(posedge clk);
        valid <= 1'b1;
        op <= o;
        bank <= b;
        row <= {b, 11'h0a5};
        col <= d[8:0];
        wd <= d;
        @(negedge clk);
        for (int n = 0; ready !== 1'b1; n++) step_neg(n);
        @(posedge clk);
        if (o == sdrtc_pkg::OP_SELFREF) repeat (30) @(posedge clk);
        if (o == sdrtc_pkg::OP_READ || o == sdrtc_pkg::OP_WRITE) begin
            for (int n = 0; {cs_n, ras_n, cas_n} !== 3'b010; n++) step_neg(n);
            @(posedge clk);
        end
        valid <= 1'b0;
    endtask
    task automatic write_read(input logic [1:0] b, input logic [31:0] d);
        request(sdrtc_pkg::OP_WRITE, b, d);
        request(sdrtc_pkg::OP_READ, b, d);
        for (int n = 0; rvalid !== 1'b1; n++) step_neg(n);
        `CHK(rdata, d)
    endtask
    task automatic sc_banks();
        for (int b = 0; b < 4; b++) write_read(b[1:0], 32'h5a00_0100 + b);
        `CHK(viol, 0)
    endtask
    task automatic sc_refresh();
        request(sdrtc_pkg::OP_REFRESH, 2'h1, 32'h0);
        request(sdrtc_pkg::OP_REFRESH, 2'h1, 32'h0);
        write_read(2'h1, 32'hc3c3_0011);
        `CHK(viol, 0)
    endtask
    task automatic sc_selfref();
        request(sdrtc_pkg::OP_SELFREF, 2'h2, 32'h0);
        write_read(2'h2, 32'h0f0f_0022);
        `CHK(viol, 0)
    endtask
    task automatic sc_latency3();
        power_up(1'b1);
        write_read(2'h3, 32'ha5a5_0033);
        `CHK(viol, 0)
    endtask
    initial begin
        power_up(1'b0);
        sc_banks();
        sc_refresh();
        sc_selfref();
        sc_latency3();
        print_verdict();
    end
endmodule
